// ### core/clock_failsafe_pkg.sv
package clock_failsafe_pkg;

  // Register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] cmd_offset = 8'h08;
  localparam logic [7:0] config_offset = 8'h0C;

  // Control register fields
  localparam int source_select_lsb = 0;
  localparam int freq_select_lsb = 4;
  localparam int fail_int_enable_bit = 8;
  localparam int global_int_enable_bit = 9;

  // Status register fields
  localparam int running_flag_bit = 0;
  localparam int fail_flag_bit = 1;
  localparam int failsafe_bit = 2;
  localparam int powerdown_bit = 3;
  localparam int timeout_bit = 4;
  localparam int asleep_bit = 5;
  localparam int clock_sel_lsb = 8;

  // Command register fields (write-one actions)
  localparam int cmd_sleep_bit = 0;
  localparam int cmd_clear_fail_bit = 1;

  // Config register fields
  localparam int monitor_enable_bit = 0;
  localparam int two_speed_bit = 1;
  localparam int primary_mode_lsb = 4;

  // Values after reset, and the source forced on clock failure
  localparam logic [1:0] source_select_reset = 2'h0;
  localparam logic [2:0] freq_select_reset = 3'h0;
  localparam logic [1:0] source_forced_fail = 2'h2;

  // Timing counts and wake vector
  localparam int startup_count = 1024;
  localparam int hold_low_edges = 8;
  localparam int sample_divide = 64;
  localparam logic [15:0] wake_vector = 16'h0004;

  // Primary oscillator modes
  typedef enum logic [2:0] {
    mode_low_power_crystal,
    mode_std_crystal,
    mode_high_speed_crystal,
    mode_external_clock,
    mode_resistor_cap_osc
  } primary_mode_type;

  // System clock selection shown to software
  typedef enum logic [1:0] {
    sel_primary,
    sel_internal,
    sel_secondary,
    sel_none
  } clock_sel_type;

  typedef enum logic [2:0] {
    st_run,
    st_startup,
    st_wait_fall,
    st_hold_low,
    st_sleep
  } seq_state_type;

endpackage : clock_failsafe_pkg

// ### core/clock_failsafe_sleep_control.sv
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
module clock_failsafe_sleep_control
  import clock_failsafe_pkg::*;
#(
  parameter int startup_cycles = startup_count,
  parameter int io_width = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Oscillator pins (asynchronous)
  input wire logic slow_osc_in,
  input wire logic primary_osc_in,
  input wire logic secondary_osc_in,
  // Core events
  input wire logic sleep_exec,
  input wire logic int_pending,
  input wire logic watchdog_timeout,
  input wire logic [io_width-1:0] io_out_core,
  input wire logic [io_width-1:0] io_oe_core,
  // Clock control outputs
  output logic [1:0] sys_clock_sel,
  output logic sys_clock_gate_low,
  output logic osc_driver_on,
  output logic watchdog_clear,
  output logic osc_fail_irq,
  output logic core_halt,
  output logic wake_branch,
  output logic [15:0] wake_vector_out,
  output logic [io_width-1:0] io_out,
  output logic [io_width-1:0] io_oe
);

  localparam int cnt_w = $clog2(startup_cycles + 1);

  typedef struct packed {
    logic [2:0] slow_sync;
    logic [2:0] prim_sync;
    logic [2:0] sec_sync;
    seq_state_type state;
    logic [cnt_w-1:0] startup_cnt;
    logic [3:0] hold_cnt;
    logic [5:0] div_cnt;
    logic sample_clk;
    logic monitor_latch;
    logic [1:0] source_select;
    logic [2:0] freq_select;
    logic fail_int_enable;
    logic global_int_enable;
    logic monitor_enable_fuse;
    logic two_speed_fuse;
    primary_mode_type primary_mode;
    logic running_flag;
    logic fail_flag;
    logic failsafe;
    logic powerdown_flag;
    logic timeout_flag;
    logic wd_clear;
    logic branch;
    logic [io_width-1:0] io_out_held;
    logic [io_width-1:0] io_oe_held;
    logic dphase;
    logic dwrite;
    logic [7:0] daddr;
    logic [31:0] rdata;
  } state_type;

  state_type cur_reg;
  state_type cur_next;

  logic slow_fall;
  logic prim_fall;
  logic sec_fall;
  logic crystal;
  logic two_speed;
  logic ctrl_write;
  logic cmd_sleep;
  logic cmd_clear_fail;
  logic fail_detect;
  logic sleeping;

  assign slow_fall = cur_reg.slow_sync[2] & ~cur_reg.slow_sync[1];
  assign prim_fall = cur_reg.prim_sync[2] & ~cur_reg.prim_sync[1];
  assign sec_fall = cur_reg.sec_sync[2] & ~cur_reg.sec_sync[1];
  assign crystal = cur_reg.primary_mode inside {mode_low_power_crystal, mode_std_crystal, mode_high_speed_crystal};
  assign two_speed = cur_reg.two_speed_fuse | cur_reg.monitor_enable_fuse;
  assign sleeping = cur_reg.state == st_sleep;

  always_comb begin
    logic sys_fall;
    logic sample_rise;
    logic sample_fall;
    logic sleep_req;
    sys_fall = 1'b0;
    sample_rise = 1'b0;
    sample_fall = 1'b0;
    sleep_req = 1'b0;
    cur_next = cur_reg;
    cur_next.slow_sync = {cur_reg.slow_sync[1:0], slow_osc_in};
    cur_next.prim_sync = {cur_reg.prim_sync[1:0], primary_osc_in};
    cur_next.sec_sync = {cur_reg.sec_sync[1:0], secondary_osc_in};
    cur_next.wd_clear = 1'b0;
    cur_next.branch = 1'b0;

    // Bus data phase
    ctrl_write = cur_reg.dphase & cur_reg.dwrite & (cur_reg.daddr == ctrl_offset);
    cmd_sleep = cur_reg.dphase & cur_reg.dwrite & (cur_reg.daddr == cmd_offset) & hwdata[cmd_sleep_bit];
    cmd_clear_fail = cur_reg.dphase & cur_reg.dwrite & (cur_reg.daddr == cmd_offset) & hwdata[cmd_clear_fail_bit];
    if (ctrl_write) begin
      cur_next.source_select = hwdata[source_select_lsb +: 2];
      cur_next.freq_select = hwdata[freq_select_lsb +: 3];
      cur_next.fail_int_enable = hwdata[fail_int_enable_bit];
      cur_next.global_int_enable = hwdata[global_int_enable_bit];
      cur_next.failsafe = 1'b0;
    end
    if (cur_reg.dphase & cur_reg.dwrite & (cur_reg.daddr == config_offset)) begin
      cur_next.monitor_enable_fuse = hwdata[monitor_enable_bit];
      cur_next.two_speed_fuse = hwdata[two_speed_bit];
      cur_next.primary_mode = primary_mode_type'(hwdata[primary_mode_lsb +: 3]);
    end
    cur_next.dphase = hsel & hready & htrans[1];
    if (hsel & hready) begin
      cur_next.dwrite = hwrite;
      cur_next.daddr = haddr[7:0];
    end
    cur_next.rdata = 32'h0000_0000;
    if (hsel & hready & htrans[1] & ~hwrite) begin
      case (haddr[7:0])
        ctrl_offset: begin
          cur_next.rdata[source_select_lsb +: 2] = cur_reg.source_select;
          cur_next.rdata[freq_select_lsb +: 3] = cur_reg.freq_select;
          cur_next.rdata[fail_int_enable_bit] = cur_reg.fail_int_enable;
          cur_next.rdata[global_int_enable_bit] = cur_reg.global_int_enable;
        end
        status_offset: begin
          cur_next.rdata[running_flag_bit] = cur_reg.running_flag;
          cur_next.rdata[fail_flag_bit] = cur_reg.fail_flag;
          cur_next.rdata[failsafe_bit] = cur_reg.failsafe;
          cur_next.rdata[powerdown_bit] = cur_reg.powerdown_flag;
          cur_next.rdata[timeout_bit] = cur_reg.timeout_flag;
          cur_next.rdata[asleep_bit] = sleeping;
          cur_next.rdata[clock_sel_lsb +: 2] = sys_clock_sel;
        end
        config_offset: begin
          cur_next.rdata[monitor_enable_bit] = cur_reg.monitor_enable_fuse;
          cur_next.rdata[two_speed_bit] = cur_reg.two_speed_fuse;
          cur_next.rdata[primary_mode_lsb +: 3] = cur_reg.primary_mode;
        end
        default: cur_next.rdata = 32'h0000_0000;
      endcase
    end

    // Sample clock: slow oscillator / 64
    if (slow_fall) begin
      cur_next.div_cnt = cur_reg.div_cnt + 6'h01;
      if (cur_reg.div_cnt == 6'(sample_divide / 2 - 1)) begin
        cur_next.sample_clk = 1'b1;
        sample_rise = 1'b1;
      end else if (cur_reg.div_cnt == 6'(sample_divide - 1)) begin
        cur_next.sample_clk = 1'b0;
        sample_fall = 1'b1;
      end
    end

    // Monitored clock falling edge
    case (sys_clock_sel)
      sel_primary: sys_fall = prim_fall;
      sel_secondary: sys_fall = sec_fall;
      default: sys_fall = slow_fall;
    endcase
    if (sample_rise) begin
      cur_next.monitor_latch = 1'b0;
    end else if (sys_fall) begin
      cur_next.monitor_latch = 1'b1;
    end
    fail_detect = cur_reg.monitor_enable_fuse & sample_fall & ~cur_reg.monitor_latch
      & ~cur_reg.failsafe & (cur_reg.state == st_run)
      & (sys_clock_sel != sel_internal);
    if (fail_detect) begin
      cur_next.failsafe = 1'b1;
      cur_next.fail_flag = 1'b1;
      cur_next.source_select = source_forced_fail;
      cur_next.wd_clear = 1'b1;
      cur_next.running_flag = 1'b0;
    end else if (cmd_clear_fail) begin
      cur_next.fail_flag = 1'b0;
    end

    // Start-up and sleep sequence
    sleep_req = sleep_exec | cmd_sleep;
    case (cur_reg.state)
      st_run: begin
        if (sleep_req & ~int_pending) begin
          cur_next.wd_clear = 1'b1;
          cur_next.powerdown_flag = 1'b0;
          cur_next.timeout_flag = 1'b1;
          cur_next.failsafe = 1'b0;
          cur_next.running_flag = 1'b0;
          cur_next.io_out_held = io_out_core;
          cur_next.io_oe_held = io_oe_core;
          cur_next.state = st_sleep;
        end
      end
      st_startup: begin
        if (sleep_req & ~int_pending) begin
          cur_next.state = st_sleep;
          cur_next.wd_clear = 1'b1;
          cur_next.powerdown_flag = 1'b0;
          cur_next.timeout_flag = 1'b1;
          cur_next.io_out_held = io_out_core;
          cur_next.io_oe_held = io_oe_core;
        end else if (ctrl_write && hwdata[source_select_lsb +: 2] != source_select_reset) begin
          cur_next.state = st_run;
        end else if (prim_fall) begin
          cur_next.startup_cnt = cur_reg.startup_cnt + cnt_w'(1);
          if (cur_reg.startup_cnt == cnt_w'(startup_cycles - 1)) begin
            cur_next.state = st_wait_fall;
          end
        end
      end
      st_wait_fall: begin
        if (slow_fall) begin
          cur_next.running_flag = 1'b1;
          cur_next.hold_cnt = 4'h0;
          cur_next.state = st_hold_low;
        end
      end
      st_hold_low: begin
        if (prim_fall) begin
          cur_next.hold_cnt = cur_reg.hold_cnt + 4'h1;
          if (cur_reg.hold_cnt == 4'(hold_low_edges - 1)) begin
            cur_next.state = st_run;
          end
        end
      end
      st_sleep: begin
        if (watchdog_timeout) begin
          cur_next.timeout_flag = 1'b0;
        end
        if (watchdog_timeout | int_pending) begin
          cur_next.branch = int_pending & cur_reg.global_int_enable;
          cur_next.startup_cnt = '0;
          cur_next.state = (two_speed & crystal) ? st_startup : st_run;
        end
      end
      default: cur_next.state = st_run;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_reg <= '0;
      cur_reg.state <= st_startup;
      cur_reg.source_select <= source_select_reset;
      cur_reg.freq_select <= freq_select_reset;
      cur_reg.monitor_enable_fuse <= 1'b1;
      cur_reg.two_speed_fuse <= 1'b1;
      cur_reg.primary_mode <= mode_std_crystal;
      cur_reg.powerdown_flag <= 1'b1;
      cur_reg.timeout_flag <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs
  always_comb begin
    if (cur_reg.failsafe) begin
      sys_clock_sel = sel_internal;
    end else if (cur_reg.state == st_sleep) begin
      sys_clock_sel = sel_none;
    end else if (cur_reg.state == st_run) begin
      case (cur_reg.source_select)
        2'h1: sys_clock_sel = sel_secondary;
        2'h0: sys_clock_sel = sel_primary;
        default: sys_clock_sel = sel_internal;
      endcase
    end else if (cur_reg.state == st_startup && !crystal) begin
      sys_clock_sel = sel_primary;
    end else begin
      sys_clock_sel = sel_internal;
    end
  end

  assign sys_clock_gate_low = cur_reg.state == st_hold_low;
  assign osc_driver_on = ~sleeping;
  assign watchdog_clear = cur_reg.wd_clear;
  assign osc_fail_irq = cur_reg.fail_flag & cur_reg.fail_int_enable;
  assign core_halt = sleeping;
  assign wake_branch = cur_reg.branch;
  assign wake_vector_out = wake_vector;
  assign io_out = sleeping ? cur_reg.io_out_held : io_out_core;
  assign io_oe = sleeping ? cur_reg.io_oe_held : io_oe_core;
  assign hrdata = cur_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : clock_failsafe_sleep_control

// ### tb/clock_failsafe_props.sv
module clock_failsafe_props
  import clock_failsafe_pkg::*;
#(
  parameter int io_width = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Core events
  input wire logic sleep_exec,
  input wire logic int_pending,
  input wire logic watchdog_timeout,
  // Clock control outputs
  input wire logic [1:0] sys_clock_sel,
  input wire logic sys_clock_gate_low,
  input wire logic osc_driver_on,
  input wire logic watchdog_clear,
  input wire logic core_halt,
  input wire logic [15:0] wake_vector_out,
  input wire logic [io_width-1:0] io_out,
  input wire logic [io_width-1:0] io_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("Bus answer not ready or not okay");
  a_hold_then_primary: assert property (
    $fell(sys_clock_gate_low) && !core_halt |-> sys_clock_sel == sel_primary)
    else $error("Hold phase did not end on the primary clock");
  a_sleep_driver_off: assert property (core_halt |-> !osc_driver_on)
    else $error("Oscillator driver on while asleep");
  a_sleep_clears_wdt: assert property (
    $rose(core_halt) |-> $past(watchdog_clear) or ##[0:1] watchdog_clear)
    else $error("Sleep entry without watchdog clear");
  a_sleep_io_frozen: assert property (
    core_halt && $past(core_halt) |-> $stable(io_out) && $stable(io_oe))
    else $error("Port drive changed while asleep");
  a_pending_sleep_nop: assert property (
    sleep_exec && int_pending && !core_halt |=> !core_halt [*2])
    else $error("Sleep with pending interrupt halted the core");
  a_timeout_wakes: assert property (
    core_halt && watchdog_timeout |-> ##[1:4] !core_halt)
    else $error("Watchdog timeout did not wake the core");
  a_int_wakes: assert property (
    core_halt && int_pending |-> ##[1:4] !core_halt)
    else $error("Enabled interrupt did not wake the core");
  a_vector_fixed: assert property (wake_vector_out == 16'h0004)
    else $error("Interrupt vector wrong");
endmodule : clock_failsafe_props

bind clock_failsafe_sleep_control clock_failsafe_props #(.io_width(io_width)) i_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .sleep_exec(sleep_exec),
  .int_pending(int_pending), .watchdog_timeout(watchdog_timeout), .sys_clock_sel(sys_clock_sel),
  .sys_clock_gate_low(sys_clock_gate_low), .osc_driver_on(osc_driver_on), .watchdog_clear(watchdog_clear),
  .core_halt(core_halt), .wake_vector_out(wake_vector_out), .io_out(io_out), .io_oe(io_oe));

// ### tb/tb_top.sv
module tb_top
  import clock_failsafe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, sys_clock_sel;
  logic [2:0] hsize = 3'h2;
  logic slow_osc_in = 1'h0, primary_osc_in = 1'h0, secondary_osc_in = 1'h0, prim_on = 1'h1;
  logic sleep_exec = 1'h0, int_pending = 1'h0, watchdog_timeout = 1'h0;
  logic [7:0] io_out_core = 8'h0, io_oe_core = 8'h0, io_out, io_oe;
  logic gate_low, drv_on, wdt_clr, fail_irq, halt, branch, wdt_seen = 1'h0, br_seen = 1'h0;
  logic [15:0] vec;
  int errors = 0, checks_done = 0, cyc = 0, t_rel = 0;

  clock_failsafe_sleep_control #(.startup_cycles(16), .io_width(8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .slow_osc_in(slow_osc_in), .primary_osc_in(primary_osc_in), .secondary_osc_in(secondary_osc_in),
    .sleep_exec(sleep_exec), .int_pending(int_pending), .watchdog_timeout(watchdog_timeout),
    .io_out_core(io_out_core), .io_oe_core(io_oe_core), .sys_clock_sel(sys_clock_sel),
    .sys_clock_gate_low(gate_low), .osc_driver_on(drv_on), .watchdog_clear(wdt_clr), .osc_fail_irq(fail_irq),
    .core_halt(halt), .wake_branch(branch), .wake_vector_out(vec), .io_out(io_out), .io_oe(io_oe));

  assign hready = hreadyout;
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  // Oscillators: slow 16 cycles, primary 4, secondary 8
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    slow_osc_in <= cyc[3];
    secondary_osc_in <= cyc[2];
    if (prim_on) primary_osc_in <= cyc[1];
    if (wdt_clr === 1'h1) wdt_seen <= 1'h1;
    if (branch === 1'h1) br_seen <= 1'h1;
  end

  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bound(input int n, input int max);
    if (n >= max) begin
      errors++;
      end_sim();
    end
  endtask : bound

  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 64);
    bound(n, 64);
  endtask : rdy

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
    @(posedge hclk);
  endtask : xfer

  task automatic poll(input int b, input int max);
    int n;
    n = 0;
    do begin
      xfer(1'h0, status_offset, 32'h0);
      n++;
    end while (rd[b] !== 1'h1 && n < max);
    bound(n, max);
  endtask : poll

  task automatic s_reset();
    xfer(1'h0, status_offset, 32'h0);
    chk("status", rd[9:0], 10'h118);
    xfer(1'h0, ctrl_offset, 32'h0);
    chk("ctrl", rd[6:0], 7'h0);
    xfer(1'h0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask : s_reset

  task automatic s_nop_sleep();
    int_pending <= 1'h1;
    sleep_exec <= 1'h1;
    @(posedge hclk);
    sleep_exec <= 1'h0;
    repeat (3) @(posedge hclk);
    int_pending <= 1'h0;
    xfer(1'h0, status_offset, 32'h0);
    chk("nop sleep", rd[5:3], 3'h3);
  endtask : s_nop_sleep

  task automatic s_startup();
    int n;
    poll(running_flag_bit, 200);
    chk("timer span", (cyc - t_rel) > 56, 1'h1);
    chk("hold low", gate_low, 1'h1);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (sys_clock_sel !== sel_primary && n < 100);
    bound(n, 100);
    chk("gate after hold", gate_low, 1'h0);
    @(posedge hclk);
  endtask : s_startup

  task automatic s_fail();
    xfer(1'h1, ctrl_offset, 32'h100);
    wdt_seen <= 1'h0;
    prim_on <= 1'h0;
    poll(fail_flag_bit, 1500);
    chk("failsafe", rd[9:1], 9'h8F);
    chk("fail irq", fail_irq, 1'h1);
    chk("wdt clear", wdt_seen, 1'h1);
    xfer(1'h0, ctrl_offset, 32'h0);
    chk("forced select", rd[1:0], source_forced_fail);
    repeat (1100) @(posedge hclk);
    xfer(1'h0, status_offset, 32'h0);
    chk("failsafe holds", rd[2:1], 2'h3);
    xfer(1'h1, ctrl_offset, 32'h1);
    xfer(1'h0, status_offset, 32'h0);
    chk("failsafe exit", rd[2:1], 2'h1);
    chk("irq masked", fail_irq, 1'h0);
    xfer(1'h1, cmd_offset, 32'h2);
    xfer(1'h0, status_offset, 32'h0);
    chk("flag cleared", rd[1], 1'h0);
  endtask : s_fail

  task automatic s_sleep();
    io_out_core <= 8'hA5;
    io_oe_core <= 8'h0F;
    wdt_seen <= 1'h0;
    @(posedge hclk);
    sleep_exec <= 1'h1;
    @(posedge hclk);
    sleep_exec <= 1'h0;
    io_out_core <= 8'h5A;
    io_oe_core <= 8'hF0;
    repeat (3) @(posedge hclk);
    chk("asleep", {halt, drv_on, wdt_seen}, 3'h5);
    chk("ports held", {io_oe, io_out}, 16'h0FA5);
    xfer(1'h0, status_offset, 32'h0);
    chk("sleep flags", rd[5:3], 3'h6);
    watchdog_timeout <= 1'h1;
    @(posedge hclk);
    watchdog_timeout <= 1'h0;
    repeat (4) @(posedge hclk);
    chk("woken", halt, 1'h0);
    chk("ports live", io_out, 8'h5A);
    xfer(1'h0, status_offset, 32'h0);
    chk("timeout flag", rd[5:4], 2'h0);
  endtask : s_sleep

  task automatic s_int_wake();
    for (int g = 0; g < 2; g++) begin
      br_seen <= 1'h0;
      xfer(1'h1, ctrl_offset, (g != 0) ? 32'h201 : 32'h1);
      xfer(1'h1, cmd_offset, 32'h1);
      @(posedge hclk);
      chk("halted", halt, 1'h1);
      int_pending <= 1'h1;
      repeat (6) @(posedge hclk);
      int_pending <= 1'h0;
      chk("branch", br_seen, g[0]);
      chk("int wake", halt, 1'h0);
    end
  endtask : s_int_wake

  task automatic s_dead_crystal();
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (1500) @(posedge hclk);
    xfer(1'h0, status_offset, 32'h0);
    chk("no false fail", {rd[9:8], rd[1:0]}, 4'h4);
    xfer(1'h1, config_offset, 32'h33);
    xfer(1'h0, status_offset, 32'h0);
    chk("direct primary", rd[9:8], 2'h0);
  endtask : s_dead_crystal

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    t_rel = cyc;
    @(posedge hclk);
    s_reset();
    s_nop_sleep();
    s_startup();
    s_fail();
    s_sleep();
    s_int_wake();
    s_dead_crystal();
    end_sim();
  end

  initial begin
    repeat (90000) @(posedge hclk);
    errors++;
    end_sim();
  end
endmodule : tb_top
